// *** verilog/xie_ext_irq.v ***
//Contract
//- enable bit 7 gates LIN interrupt
//- enable bit 6 gates timer 3 flags
//- enable bit 5 gates comparator 1 flags
//- enable bit 4 gates comparator 0 flags
//- enable bit 3 gates counter array requests
//- enable bit 2 gates ADC done flag
//- enable bit 1 gates ADC window flag
//- enable bit 0 gates SMBus requests
//- priority bits 7,6: LIN, timer 3
//- priority bits 5,4: comparators 1, 0
//- priority bits 3..1: PCA, ADC done, window
//- priority bit 0: SMBus level
//- mask register at E6, every page
//- priority register at F6, pages 00/0F
//- cleared global enable blocks all sources
`timescale 1ns/1ps
`default_nettype none
`include "xie_defs.vh"
module xie_ext_irq (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // sfr bus from the core
  input wire [7:0] i_sfr_addr,
  input wire [7:0] i_sfr_page,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_wdata,
  output reg [7:0] o_sfr_rdata,
  output wire o_sfr_hit,
  // core interrupt control
  input wire i_global_interrupt_enable,
  input wire i_vector_ack,
  input wire i_reti,
  // peripheral flags
  input wire i_lin_interrupt_flag,
  input wire i_timer3_low_overflow_flag,
  input wire i_timer3_high_overflow_flag,
  input wire i_comp1_rising_flag,
  input wire i_comp1_falling_flag,
  input wire i_comp0_rising_flag,
  input wire i_comp0_falling_flag,
  input wire i_counter_array_irq,
  input wire i_adc_done_flag,
  input wire i_adc_window_flag,
  input wire i_smbus_irq,
  // requests to the core
  output reg o_irq_req,
  output reg o_irq_high,
  output reg [2:0] o_irq_src,
  output wire [1:0] o_in_service,
  // register contents
  output wire [7:0] o_mask,
  output wire [7:0] o_prio
);
  wire [7:0] mask_q;
  wire [7:0] prio_q;
  wire hit_mask;
  wire hit_prio;
  wire [7:0] raw;
  wire [7:0] pend;
  wire [7:0] pend_hi;
  wire [7:0] pend_lo;
  wire any_hi;
  wire any_lo;
  wire [2:0] idx_hi;
  wire [2:0] idx_lo;
  reg hi_active_r;
  reg lo_active_r;
  reg [2:0] cand_idx;
  reg cand_ok;
  reg cand_high;

  xie_sfr_reg #(.ADDR(`XIE_ADDR_MASK), .ALL_PAGES(1)) u_mask (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_addr(i_sfr_addr),
    .i_page(i_sfr_page),
    .i_wr(i_sfr_wr),
    .i_wdata(i_sfr_wdata),
    .o_hit(hit_mask),
    .o_q(mask_q)
  );

  xie_sfr_reg #(.ADDR(`XIE_ADDR_PRIO), .ALL_PAGES(0)) u_prio (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_addr(i_sfr_addr),
    .i_page(i_sfr_page),
    .i_wr(i_sfr_wr),
    .i_wdata(i_sfr_wdata),
    .o_hit(hit_prio),
    .o_q(prio_q)
  );

  assign o_mask = mask_q;
  assign o_prio = prio_q;
  assign o_sfr_hit = hit_mask | hit_prio;

  // read data is registered; unmapped addresses return zero
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sfr_rdata <= `XIE_RESET_VAL;
    end else if (i_sfr_rd) begin
      if (hit_mask) begin
        o_sfr_rdata <= mask_q;
      end else if (hit_prio) begin
        o_sfr_rdata <= prio_q;
      end else begin
        o_sfr_rdata <= `XIE_RESET_VAL;
      end
    end
  end

  // combine each source's flags into one raw request
  assign raw[`XIE_BIT_LIN] = i_lin_interrupt_flag;
  assign raw[`XIE_BIT_TMR3] = i_timer3_low_overflow_flag | i_timer3_high_overflow_flag;
  assign raw[`XIE_BIT_CMP1] = i_comp1_rising_flag | i_comp1_falling_flag;
  assign raw[`XIE_BIT_CMP0] = i_comp0_rising_flag | i_comp0_falling_flag;
  assign raw[`XIE_BIT_PCA] = i_counter_array_irq;
  assign raw[`XIE_BIT_ADC_DONE] = i_adc_done_flag;
  assign raw[`XIE_BIT_ADC_WIN] = i_adc_window_flag;
  assign raw[`XIE_BIT_SMB] = i_smbus_irq;

  // per-source gating and priority split
  genvar g;
  generate
    for (g = 0; g < `XIE_NSRC; g = g + 1) begin : g_src
      assign pend[g] = raw[g] & mask_q[g] & i_global_interrupt_enable;
      assign pend_hi[g] = pend[g] & prio_q[g];
      assign pend_lo[g] = pend[g] & ~prio_q[g];
    end
  endgenerate

  xie_prio_pick #(.N(`XIE_NSRC)) u_pick_hi (
    .i_req(pend_hi),
    .o_any(any_hi),
    .o_idx(idx_hi)
  );

  xie_prio_pick #(.N(`XIE_NSRC)) u_pick_lo (
    .i_req(pend_lo),
    .o_any(any_lo),
    .o_idx(idx_lo)
  );

  // a high request may interrupt a low routine; nothing interrupts a high one
  always @* begin
    cand_ok = 1'b0;
    cand_high = 1'b0;
    cand_idx = `XIE_NO_SRC;
    if (!hi_active_r) begin
      if (any_hi) begin
        cand_ok = 1'b1;
        cand_high = 1'b1;
        cand_idx = idx_hi;
      end else if (any_lo && !lo_active_r) begin
        cand_ok = 1'b1;
        cand_idx = idx_lo;
      end
    end
  end

  // registered request; flags cleared by software drop it one cycle later
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq_req <= 1'b0;
      o_irq_high <= 1'b0;
      o_irq_src <= `XIE_NO_SRC;
    end else begin
      o_irq_req <= cand_ok & ~i_vector_ack;
      o_irq_high <= cand_high;
      o_irq_src <= cand_idx;
    end
  end

  // service level tracking; return pops the highest active level
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hi_active_r <= 1'b0;
      lo_active_r <= 1'b0;
    end else if (i_vector_ack && o_irq_req) begin
      if (o_irq_high) begin
        hi_active_r <= 1'b1;
      end else begin
        lo_active_r <= 1'b1;
      end
    end else if (i_reti) begin
      if (hi_active_r) begin
        hi_active_r <= 1'b0;
      end else begin
        lo_active_r <= 1'b0;
      end
    end
  end

  assign o_in_service = {hi_active_r, lo_active_r};
endmodule // xie_ext_irq
`default_nettype wire

// *** verilog/xie_defs.vh ***
`ifndef XIE_DEFS_VH
`define XIE_DEFS_VH
// special-function addresses and page codes
`define XIE_ADDR_MASK 8'hE6
`define XIE_ADDR_PRIO 8'hF6
`define XIE_PAGE_ZERO 8'h00
`define XIE_PAGE_CFG 8'h0F
`define XIE_RESET_VAL 8'h00
// source bit positions, shared by mask and priority registers
`define XIE_BIT_LIN 7
`define XIE_BIT_TMR3 6
`define XIE_BIT_CMP1 5
`define XIE_BIT_CMP0 4
`define XIE_BIT_PCA 3
`define XIE_BIT_ADC_DONE 2
`define XIE_BIT_ADC_WIN 1
`define XIE_BIT_SMB 0
`define XIE_NSRC 8
`define XIE_NO_SRC 3'h0
`endif

// *** verilog/xie_sfr_reg.v ***
`timescale 1ns/1ps
`default_nettype none
`include "xie_defs.vh"
// one 8-bit read/write special-function register with page qualification
module xie_sfr_reg #(
  parameter [7:0] ADDR = `XIE_ADDR_MASK,
  parameter ALL_PAGES = 1
) (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // sfr bus
  input wire [7:0] i_addr,
  input wire [7:0] i_page,
  input wire i_wr,
  input wire [7:0] i_wdata,
  // register
  output wire o_hit,
  output reg [7:0] o_q
);
  wire page_ok;
  assign page_ok = (ALL_PAGES != 0) || (i_page == `XIE_PAGE_ZERO) ||
                   (i_page == `XIE_PAGE_CFG);
  assign o_hit = (i_addr == ADDR) && page_ok;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_q <= `XIE_RESET_VAL;
    end else if (i_wr && o_hit) begin
      o_q <= i_wdata;
    end
  end
endmodule // xie_sfr_reg
`default_nettype wire

// *** verilog/xie_prio_pick.v ***
`timescale 1ns/1ps
`default_nettype none
`include "xie_defs.vh"
// fixed-order pick among a request vector; bit 7 wins ties
module xie_prio_pick #(
  parameter N = `XIE_NSRC
) (
  // requests
  input wire [N-1:0] i_req,
  // result
  output reg o_any,
  output reg [2:0] o_idx
);
  integer k;
  always @* begin
    o_any = 1'b0;
    o_idx = `XIE_NO_SRC;
    for (k = 0; k < N; k = k + 1) begin
      if (i_req[k]) begin
        o_any = 1'b1;
        o_idx = k[2:0];
      end
    end
  end
endmodule // xie_prio_pick
`default_nettype wire

// *** testbench/xie_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module xie_asserts (
  input wire logic i_clk, i_nrst, i_sfr_wr, i_sfr_rd, i_global_interrupt_enable,
  input wire logic i_vector_ack, i_reti, o_irq_req, o_irq_high,
  input wire logic [7:0] i_sfr_addr, i_sfr_page, i_sfr_wdata, o_mask, o_prio,
  input wire logic [2:0] o_irq_src,
  input wire logic [1:0] o_in_service
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire pg = i_sfr_page == 8'h00 || i_sfr_page == 8'h0F;
  wire wm = i_sfr_wr && i_sfr_addr == 8'hE6;
  wire wp = i_sfr_wr && i_sfr_addr == 8'hF6;
  a_mask_write: assert property (wm |=> o_mask == $past(i_sfr_wdata))
    else $error("mask write lost");
  a_prio_write: assert property (wp && pg |=> o_prio == $past(i_sfr_wdata))
    else $error("prio write lost");
  a_prio_page: assert property (wp && !pg |=> $stable(o_prio))
    else $error("prio written off page");
  a_src_masked: assert property (o_irq_req |-> ($past(o_mask) >> o_irq_src) & 8'h01)
    else $error("masked source offered");
  a_prio_level: assert property (o_irq_req |->
    (($past(o_prio) >> o_irq_src) & 8'h01) == {7'h0, o_irq_high})
    else $error("wrong level");
  a_global_block: assert property (!i_global_interrupt_enable |=> !o_irq_req)
    else $error("request while globally off");
  a_high_block: assert property (o_in_service[1] && !i_reti |=> !o_irq_req)
    else $error("request during high service");
  a_ack_drop: assert property (i_vector_ack |=> !o_irq_req)
    else $error("request held after ack");
  c_high: cover property (o_irq_req && o_irq_high);
  c_nested: cover property (o_in_service == 2'b11);
  c_off_page: cover property (wp && !pg);
endmodule // xie_asserts
bind xie_ext_irq xie_asserts u_chk (.*);
`default_nettype wire

// *** testbench/xie_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module xie_core_model (
  input wire logic i_clk, i_en, i_req,
  output logic o_ack = 1'b0,
  output logic o_reti = 1'b0
);
  // long service so a high source can preempt mid-routine
  logic [4:0] cnt_r = 5'h00;
  always @(posedge i_clk) begin
    o_ack <= i_en && i_req && !o_ack;
    o_reti <= cnt_r == 5'h01;
    cnt_r <= o_ack ? 5'h14 : (cnt_r != 5'h00 ? cnt_r - 5'h01 : 5'h00);
  end
endmodule // xie_core_model
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, ge = 1'b0, en = 1'b0;
  logic [7:0] addr = 8'h00, page = 8'h00, wdata = 8'h00, rdata, mask, prio;
  logic [10:0] fl = 11'h000;
  logic req, high, ack, reti, hit;
  logic [2:0] src;
  logic [1:0] ins;
  int fail_count = 0, num_checks = 0;
  localparam int SB[11] = '{7, 6, 6, 5, 5, 4, 4, 3, 2, 1, 0};
  always #2.5 clk = ~clk;
  xie_ext_irq u_xie_ext_irq (.i_clk(clk), .i_nrst(nrst), .i_sfr_addr(addr),
    .i_sfr_page(page), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata),
    .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_global_interrupt_enable(ge),
    .i_vector_ack(ack), .i_reti(reti), .i_lin_interrupt_flag(fl[0]),
    .i_timer3_low_overflow_flag(fl[1]), .i_timer3_high_overflow_flag(fl[2]),
    .i_comp1_rising_flag(fl[3]), .i_comp1_falling_flag(fl[4]),
    .i_comp0_rising_flag(fl[5]), .i_comp0_falling_flag(fl[6]),
    .i_counter_array_irq(fl[7]), .i_adc_done_flag(fl[8]), .i_adc_window_flag(fl[9]),
    .i_smbus_irq(fl[10]), .o_irq_req(req), .o_irq_high(high), .o_irq_src(src),
    .o_in_service(ins), .o_mask(mask), .o_prio(prio));
  xie_core_model u_xie_core_model (.i_clk(clk), .i_en(en), .i_req(req), .o_ack(ack),
    .o_reti(reti));
  task automatic chk(input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic acc(input logic [7:0] a, p, d, input logic w);
    @(posedge clk);
    addr <= a; page <= p; wdata <= d; wr <= w; rd <= !w;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b0;
    #1;
  endtask
  task automatic rst;
    nrst <= 1'b0; en <= 1'b0; fl <= 11'h000; ge <= 1'b1;
    cyc(3);
    nrst <= 1'b1;
  endtask
  task automatic t_regs;
    chk(mask, 8'h00);
    chk(prio, 8'h00);
    acc(8'hF6, 8'h05, 8'hA5, 1'b1);
    chk(prio, 8'h00);
    chk(hit, 1'b0);
    acc(8'hF6, 8'h0F, 8'h3C, 1'b1);
    chk(prio, 8'h3C);
    chk(hit, 1'b1);
    acc(8'hE6, 8'h05, 8'h81, 1'b1);
    chk(mask, 8'h81);
    chk(hit, 1'b1);
    acc(8'hE6, 8'h07, 8'h00, 1'b0);
    chk(rdata, 8'h81);
    acc(8'hF6, 8'h05, 8'h00, 1'b0);
    chk(rdata, 8'h00);
    acc(8'hF6, 8'h00, 8'h00, 1'b0);
    chk(rdata, 8'h3C);
  endtask
  // every flag alone, both levels, then global off and mask off
  task automatic t_gate;
    logic [7:0] b;
    for (int j = 0; j < 2; j++)
      for (int k = 0; k < 11; k++) begin
        b = 8'h01 << SB[k];
        acc(8'hE6, 8'h00, b, 1'b1);
        acc(8'hF6, 8'h00, j ? 8'hFF : 8'h00, 1'b1);
        fl[k] <= 1'b1;
        cyc(2);
        chk(req, 1'b1);
        chk(src, SB[k][2:0]);
        chk(high, j[0]);
        ge <= 1'b0;
        cyc(2);
        chk(req, 1'b0);
        ge <= 1'b1;
        acc(8'hE6, 8'h00, ~b, 1'b1);
        cyc(1);
        chk(req, 1'b0);
        fl <= 11'h000;
      end
  endtask
  task automatic t_prio;
    rst;
    acc(8'hE6, 8'h00, 8'hFF, 1'b1);
    acc(8'hF6, 8'h0F, 8'h80, 1'b1);
    en <= 1'b1;
    fl[10] <= 1'b1;
    cyc(5);
    chk(ins, 2'b01);
    fl[0] <= 1'b1;
    cyc(5);
    chk(ins, 2'b11);
    chk(req, 1'b0);
    fl[0] <= 1'b0;
    cyc(20);
    chk(ins, 2'b01);
    chk(req, 1'b0);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    rst;
    t_regs;
    t_gate;
    t_prio;
    end_of_test;
  end
  initial begin
    #20000;
    fail_count++;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
